// File: hw/ebl_pkg.sv
// ebl_pkg: constants, types and lane helpers for the byte-lane steering
package ebl_pkg;
    // bus geometry
    localparam int unsigned LANES = 4;
    localparam int unsigned WORD_W = LANES * 8;
    // register offsets (dword aligned byte addresses)
    localparam logic [7:0] SCTL0_OFS = 8'h00;
    localparam logic [7:0] STATUS_OFS = 8'h04;
    localparam logic [7:0] CTRL_OFS = 8'h08;
    // reset values
    localparam logic [7:0] SCTL0_RST = 8'h00;
    localparam logic CTRL_EN_RST = 1'b1;
    // field positions
    localparam int unsigned CTRL_EN_BIT = 0;
    localparam int unsigned STAT_BIG_BIT = 0;
    localparam int unsigned STAT_RXBUSY_BIT = 1;
    localparam int unsigned STAT_TXBUSY_BIT = 2;
    localparam int unsigned STAT_PIN_BIT = 3;
    // byte addresses inside a dword
    localparam logic [1:0] ADDR_FIRST = 2'h0;
    localparam logic [1:0] ADDR_LAST = 2'h3;

    typedef enum logic [1:0] {
        EBL_TX_IDLE = 2'b01,
        EBL_TX_SEND = 2'b10
    } ebl_tx_st_t;

    // byte address to physical lane: big endian mirrors the lanes
    function automatic logic [1:0] ebl_lane(input logic big,
                                            input logic [1:0] a);
        ebl_lane = big ? ~a : a;
    endfunction : ebl_lane

    // pick one byte lane out of a word
    function automatic logic [7:0] ebl_get(input logic [31:0] w,
                                           input logic [1:0] l);
        ebl_get = w[{l, 3'h0} +: 8];
    endfunction : ebl_get

    // one-hot byte enable for a lane
    function automatic logic [3:0] ebl_onehot(input logic [1:0] l);
        ebl_onehot = 4'h1 << l;
    endfunction : ebl_onehot
endpackage : ebl_pkg

// File: hw/ebl_rx_if.sv
// ebl_rx_if: receive byte stream and packed word between top and packer
`timescale 1ns/10ps
interface ebl_rx_if;
    logic byte_valid;
    logic first;
    logic last;
    logic [7:0] byte_data;
    logic big;
    logic [31:0] word;
    logic [3:0] be;
    logic word_valid;
    logic busy;
    modport src (output byte_valid, first, last, byte_data, big,
                 input word, be, word_valid, busy);
    modport pk (input byte_valid, first, last, byte_data, big,
                output word, be, word_valid, busy);
endinterface : ebl_rx_if

// File: hw/ebl_pack.sv
// ebl_pack: packs incoming scsi bytes onto host bus lanes
`timescale 1ns/10ps
module ebl_pack (
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic ce_i,
    ebl_rx_if.pk rx
);
    import ebl_pkg::*;

    typedef struct packed {
        logic [1:0] pos;
        logic [31:0] acc;
        logic [3:0] abe;
        logic [31:0] word;
        logic [3:0] obe;
        logic ovalid;
    } ebl_pack_st_t;

    ebl_pack_st_t st;
    ebl_pack_st_t next_st;
    logic [1:0] pos;
    logic [1:0] lane;
    logic [31:0] nacc;
    logic [3:0] nbe;

    // place each byte at its address lane, emit on full or last byte
    always_comb begin
        next_st = st;
        next_st.ovalid = 1'b0;
        pos = rx.first ? ADDR_FIRST : st.pos;
        nacc = rx.first ? 32'h0 : st.acc;
        nbe = rx.first ? 4'h0 : st.abe;
        lane = ebl_lane(rx.big, pos);
        if (rx.byte_valid) begin
            nacc[{lane, 3'h0} +: 8] = rx.byte_data;
            nbe = nbe | ebl_onehot(lane);
            next_st.acc = nacc;
            next_st.abe = nbe;
            next_st.pos = pos + 2'h1;
            if (pos == ADDR_LAST || rx.last) begin
                next_st.word = nacc;
                next_st.obe = nbe;
                next_st.ovalid = 1'b1;
                next_st.acc = 32'h0;
                next_st.abe = 4'h0;
                next_st.pos = ADDR_FIRST;
            end
        end
    end

    // state register, frozen while the clock enable is low
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            st <= '0;
        end else if (ce_i) begin
            st <= next_st;
        end
    end

    assign rx.word = st.word;
    assign rx.be = st.obe;
    assign rx.word_valid = st.ovalid;
    assign rx.busy = (st.pos != ADDR_FIRST);

    property p_big_first;
        @(posedge clk_i) disable iff (reset_i)
        (ce_i && rx.byte_valid && rx.first && rx.big && !rx.last)
            |=> (st.abe == 4'h8) && (st.acc[31:24] == $past(rx.byte_data));
    endproperty
    a_big_first: assert property (p_big_first)
        else $error("big endian first byte not on lane three");

    property p_little_first;
        @(posedge clk_i) disable iff (reset_i)
        (ce_i && rx.byte_valid && rx.first && !rx.big && !rx.last)
            |=> (st.abe == 4'h1) && (st.acc[7:0] == $past(rx.byte_data));
    endproperty
    a_little_first: assert property (p_little_first)
        else $error("little endian first byte not on lane zero");

    property p_ascend;
        @(posedge clk_i) disable iff (reset_i)
        (ce_i && rx.byte_valid && rx.first && !rx.last) |=> st.pos == 2'h1;
    endproperty
    a_ascend: assert property (p_ascend)
        else $error("first byte did not start at address zero");
endmodule : ebl_pack

// File: hw/ebl_regs.sv
// ebl_regs: register file with endian-aware byte address decode
`timescale 1ns/10ps
module ebl_regs (
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic ce_i,
    input wire logic big_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic [ebl_pkg::WORD_W-1:0] reg_wdata_i,
    input wire logic reg_byte_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [31:0] status_i,
    input wire logic [7:0] scr_addr_i,
    input wire logic scr_rd_i,
    output logic [ebl_pkg::WORD_W-1:0] reg_rdata_o,
    output logic [7:0] scr_rdata_o,
    output logic ctrl_en_o
);
    import ebl_pkg::*;

    typedef struct packed {
        logic [7:0] sctl0;
        logic en;
        logic [31:0] rdata;
        logic [7:0] sdata;
    } ebl_regs_st_t;

    ebl_regs_st_t st;
    ebl_regs_st_t next_st;
    logic [1:0] lane;
    logic [3:0] wbe;
    logic [7:0] wofs;

    // internal word image; lanes never move with the bus mode
    function automatic logic [31:0] word_at(input logic [7:0] a,
                                            input logic [7:0] s0,
                                            input logic en,
                                            input logic [31:0] s);
        case ({a[7:2], 2'h0})
            SCTL0_OFS: word_at = {24'h0, s0};
            STATUS_OFS: word_at = s;
            CTRL_OFS: word_at = {31'h0, en};
            default: word_at = 32'h0;
        endcase
    endfunction : word_at

    // decode, read capture and byte-lane write
    always_comb begin
        next_st = st;
        wofs = {reg_addr_i[7:2], 2'h0};
        lane = ebl_lane(big_i, reg_addr_i[1:0]);
        wbe = reg_byte_i ? ebl_onehot(lane) : 4'hf;
        next_st.rdata = 32'h0;
        next_st.sdata = 8'h0;
        if (reg_rd_i) begin
            next_st.rdata = word_at(reg_addr_i, st.sctl0, st.en, status_i)
                & {{8{wbe[3]}}, {8{wbe[2]}}, {8{wbe[1]}}, {8{wbe[0]}}};
        end
        // only lane zero holds writable bits
        if (reg_wr_i && wbe[0]) begin
            if (wofs == SCTL0_OFS) begin
                next_st.sctl0 = reg_wdata_i[7:0];
            end
            if (wofs == CTRL_OFS) begin
                next_st.en = reg_wdata_i[CTRL_EN_BIT];
            end
        end
        // script side always decodes little endian, whatever the pin
        if (scr_rd_i) begin
            next_st.sdata = ebl_get(word_at(scr_addr_i, st.sctl0, st.en,
                                            status_i), scr_addr_i[1:0]);
        end
    end

    // state register
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            st <= '{sctl0: SCTL0_RST, en: CTRL_EN_RST,
                    rdata: 32'h0, sdata: 8'h0};
        end else if (ce_i) begin
            st <= next_st;
        end
    end

    assign reg_rdata_o = st.rdata;
    assign scr_rdata_o = st.sdata;
    assign ctrl_en_o = st.en;

    property p_big_byte_wr;
        @(posedge clk_i) disable iff (reset_i)
        (ce_i && reg_wr_i && reg_byte_i && big_i && reg_addr_i == 8'h03)
            |=> st.sctl0 == $past(reg_wdata_i[7:0]);
    endproperty
    a_big_byte_wr: assert property (p_big_byte_wr)
        else $error("big endian byte write at 0x03 missed control zero");

    property p_byte_rd;
        @(posedge clk_i) disable iff (reset_i)
        (ce_i && reg_rd_i && reg_byte_i && reg_addr_i[7:2] == 6'h0
            && ebl_lane(big_i, reg_addr_i[1:0]) == 2'h0)
            |=> reg_rdata_o == {24'h0, $past(st.sctl0)};
    endproperty
    a_byte_rd: assert property (p_byte_rd)
        else $error("byte read of control zero not on lane zero");

    property p_dword_rd;
        @(posedge clk_i) disable iff (reset_i)
        (ce_i && reg_rd_i && !reg_byte_i && reg_addr_i[7:2] == 6'h0)
            |=> reg_rdata_o == {24'h0, $past(st.sctl0)};
    endproperty
    a_dword_rd: assert property (p_dword_rd)
        else $error("dword read repositioned bytes");

    property p_scr_rd;
        @(posedge clk_i) disable iff (reset_i)
        (ce_i && scr_rd_i && scr_addr_i == 8'h00)
            |=> scr_rdata_o == $past(st.sctl0);
    endproperty
    a_scr_rd: assert property (p_scr_rd)
        else $error("script decode depends on bus mode");
endmodule : ebl_regs

// File: hw/ebl_steer.sv
// ebl_steer: endian byte-lane steering between scsi stream and host bus
//
// Overview of operation
// - endian order comes from the level of a mode pin, not a register
// - big endian: first scsi byte on lane three, then descending lanes
// - little endian: first scsi byte on lane zero, then ascending lanes
// - big endian rom: location zero on lane three, three on lane zero
// - little endian rom: location zero on lane zero, three on lane three
// - internal fifo and register lanes never change with the mode
// - slave accesses work in both endian modes
// - dword accesses get no byte repositioning
// - sub-dword accesses remap addresses; registers keep their lane
// - incoming scsi bytes fill ascending addresses from address zero
// - outgoing scsi bytes leave in ascending address order from zero
// - control register zero decodes at 0x03 big, 0x00 little
// - script register addresses decode little endian in both modes
// - parts without the mode pin run little endian only
//
// The implementer's own choice: strobed register access.
`timescale 1ns/10ps
module ebl_steer #(
    parameter bit HAS_MODE_PIN = 1'b1
) (
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic ce_i,
    input wire logic big_pin_i,

    // register bus
    input wire logic [7:0] reg_addr_i,
    input wire logic [ebl_pkg::WORD_W-1:0] reg_wdata_i,
    input wire logic reg_byte_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [ebl_pkg::WORD_W-1:0] reg_rdata_o,

    // script side port
    input wire logic [7:0] scr_addr_i,
    input wire logic scr_rd_i,
    output logic [7:0] scr_rdata_o,

    // scsi receive stream
    input wire logic rx_byte_valid_i,
    input wire logic [7:0] rx_byte_i,
    input wire logic rx_first_i,
    input wire logic rx_last_i,
    output logic [ebl_pkg::WORD_W-1:0] rx_word_o,
    output logic [ebl_pkg::LANES-1:0] rx_be_o,
    output logic rx_word_valid_o,

    // scsi transmit stream
    input wire logic [ebl_pkg::WORD_W-1:0] tx_word_i,
    input wire logic tx_word_valid_i,
    output logic tx_word_ready_o,
    output logic [7:0] tx_byte_o,
    output logic tx_byte_valid_o,
    input wire logic tx_byte_ready_i,

    // add-in rom bytes
    input wire logic rom_valid_i,
    input wire logic [1:0] rom_addr_i,
    input wire logic [7:0] rom_byte_i,
    output logic [ebl_pkg::WORD_W-1:0] rom_word_o,
    output logic [ebl_pkg::LANES-1:0] rom_be_o,
    output logic rom_valid_o,

    // byte order in force
    output logic big_mode_o
);
    import ebl_pkg::*;

    typedef struct packed {
        // pin synchroniser and mode
        logic pin_s1;
        logic pin_s2;
        logic big;
        // transmit unpacker
        ebl_tx_st_t tx_st;
        logic [1:0] tx_pos;
        logic [31:0] tx_word;
        logic [7:0] tx_byte;
        logic tx_bvalid;
        logic tx_wready;
        // rom lane steering
        logic [31:0] rom_word;
        logic [3:0] rom_be;
        logic rom_valid;
    } ebl_top_st_t;

    // whole state in one register
    ebl_top_st_t st;
    ebl_top_st_t next_st;

    // decode and handshake terms
    logic ctrl_en;
    logic tx_take;
    logic tx_step;
    logic mode_ok;
    logic [1:0] rom_lane;
    logic [31:0] status;

    // packer link
    ebl_rx_if rx ();

    // receive stream into the packer; disabled stream drops bytes
    assign rx.byte_valid = rx_byte_valid_i & ctrl_en;
    assign rx.first = rx_first_i;
    assign rx.last = rx_last_i;
    assign rx.byte_data = rx_byte_i;
    assign rx.big = st.big;

    ebl_pack u_pack (
        .clk_i(clk_i),
        .reset_i(reset_i),
        .ce_i(ce_i),
        .rx(rx.pk)
    );

    // status word seen by software
    always_comb begin
        status = 32'h0;
        status[STAT_BIG_BIT] = st.big;
        status[STAT_RXBUSY_BIT] = rx.busy;
        status[STAT_TXBUSY_BIT] = (st.tx_st != EBL_TX_IDLE);
        status[STAT_PIN_BIT] = st.pin_s2;
    end

    ebl_regs u_regs (
        .clk_i(clk_i),
        .reset_i(reset_i),
        .ce_i(ce_i),
        .big_i(st.big),
        .reg_addr_i(reg_addr_i),
        .reg_wdata_i(reg_wdata_i),
        .reg_byte_i(reg_byte_i),
        .reg_wr_i(reg_wr_i),
        .reg_rd_i(reg_rd_i),
        .status_i(status),
        .scr_addr_i(scr_addr_i),
        .scr_rd_i(scr_rd_i),
        .reg_rdata_o(reg_rdata_o),
        .scr_rdata_o(scr_rdata_o),
        .ctrl_en_o(ctrl_en)
    );

    // handshake terms
    assign tx_take = tx_word_valid_i && st.tx_wready;
    assign tx_step = st.tx_bvalid && tx_byte_ready_i;
    // mode may only move when no word is half packed or half sent
    assign mode_ok = (st.tx_st == EBL_TX_IDLE) && !tx_take && !rx.busy
        && !rx.byte_valid;
    // rom byte address to its lane
    assign rom_lane = ebl_lane(st.big, rom_addr_i);

    // next state: pin sync, mode, transmit unpacker, rom steering
    always_comb begin
        next_st = st;
        // two flops before the pin level is used
        next_st.pin_s1 = big_pin_i;
        next_st.pin_s2 = st.pin_s1;
        // pinless parts tie the mode to little endian
        if (mode_ok) begin
            next_st.big = HAS_MODE_PIN & st.pin_s2;
        end

        case (st.tx_st)
            EBL_TX_IDLE: begin
                next_st.tx_wready = ctrl_en;
                if (tx_take) begin
                    // address zero leaves first on the scsi side
                    next_st.tx_word = tx_word_i;
                    next_st.tx_pos = ADDR_FIRST;
                    next_st.tx_byte = ebl_get(tx_word_i,
                        ebl_lane(st.big, ADDR_FIRST));
                    next_st.tx_bvalid = 1'b1;
                    next_st.tx_wready = 1'b0;
                    next_st.tx_st = EBL_TX_SEND;
                end
            end
            EBL_TX_SEND: begin
                if (tx_step) begin
                    if (st.tx_pos == ADDR_LAST) begin
                        next_st.tx_bvalid = 1'b0;
                        next_st.tx_wready = ctrl_en;
                        next_st.tx_st = EBL_TX_IDLE;
                    end else begin
                        next_st.tx_pos = st.tx_pos + 2'h1;
                        next_st.tx_byte = ebl_get(st.tx_word,
                            ebl_lane(st.big, st.tx_pos + 2'h1));
                    end
                end
            end
            default: begin
                next_st.tx_st = EBL_TX_IDLE;
                next_st.tx_bvalid = 1'b0;
                next_st.tx_wready = 1'b0;
            end
        endcase

        // rom byte goes to the lane of its address, one-cycle pulse
        next_st.rom_valid = rom_valid_i;
        next_st.rom_word = 32'h0;
        next_st.rom_be = 4'h0;
        if (rom_valid_i) begin
            next_st.rom_word[{rom_lane, 3'h0} +: 8] = rom_byte_i;
            next_st.rom_be = ebl_onehot(rom_lane);
        end
    end

    // state register, frozen while the clock enable is low
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            st <= '0;
            // all zero is no legal one-hot state
            st.tx_st <= EBL_TX_IDLE;
        end else if (ce_i) begin
            st <= next_st;
        end
    end

    // every output comes from a flop
    assign rx_word_o = rx.word;
    assign rx_be_o = rx.be;
    assign rx_word_valid_o = rx.word_valid;
    assign tx_word_ready_o = st.tx_wready;
    assign tx_byte_o = st.tx_byte;
    assign tx_byte_valid_o = st.tx_bvalid;
    assign rom_word_o = st.rom_word;
    assign rom_be_o = st.rom_be;
    assign rom_valid_o = st.rom_valid;
    assign big_mode_o = st.big;

    // mode source, pinless parts and stability
    property p_pinless;
        @(posedge clk_i) disable iff (reset_i)
        (HAS_MODE_PIN == 1'b0) |-> !st.big;
    endproperty
    a_pinless: assert property (p_pinless)
        else $error("pinless part left little endian");

    property p_mode_src;
        @(posedge clk_i) disable iff (reset_i)
        $changed(st.big) |-> st.big == $past(st.pin_s2);
    endproperty
    a_mode_src: assert property (p_mode_src)
        else $error("mode did not follow the synchronised pin");

    property p_mode_hold;
        @(posedge clk_i) disable iff (reset_i)
        $changed(st.big) |-> $past(mode_ok);
    endproperty
    a_mode_hold: assert property (p_mode_hold)
        else $error("mode changed during a transfer");

    // transmit byte order
    property p_tx_first;
        @(posedge clk_i) disable iff (reset_i)
        (ce_i && tx_take) |=> tx_byte_valid_o
            && tx_byte_o == ebl_get($past(tx_word_i),
                                    ebl_lane(st.big, ADDR_FIRST));
    endproperty
    a_tx_first: assert property (p_tx_first)
        else $error("first scsi byte out is not address zero");

    property p_tx_next;
        @(posedge clk_i) disable iff (reset_i)
        (ce_i && tx_step && st.tx_pos != ADDR_LAST)
            |=> st.tx_pos == $past(st.tx_pos) + 2'h1;
    endproperty
    a_tx_next: assert property (p_tx_next)
        else $error("scsi bytes out not in ascending order");

    // rom lane placement
    property p_rom_big;
        @(posedge clk_i) disable iff (reset_i)
        (ce_i && rom_valid_i && st.big && rom_addr_i == 2'h0)
            |=> rom_be_o == 4'h8 && rom_word_o[31:24] == $past(rom_byte_i);
    endproperty
    a_rom_big: assert property (p_rom_big)
        else $error("big endian rom location zero not on lane three");

    property p_rom_little;
        @(posedge clk_i) disable iff (reset_i)
        (ce_i && rom_valid_i && !st.big && rom_addr_i == 2'h3)
            |=> rom_be_o == 4'h8 && rom_word_o[31:24] == $past(rom_byte_i);
    endproperty
    a_rom_little: assert property (p_rom_little)
        else $error("little endian rom location three not on lane three");

    // main scenarios reached
    c_tx_done: cover property (@(posedge clk_i)
        disable iff (reset_i)
        tx_step && st.tx_pos == ADDR_LAST);
    c_rx_word: cover property (@(posedge clk_i)
        disable iff (reset_i)
        rx_word_valid_o && rx_be_o == 4'hf && st.big);
    c_mode_flip: cover property (@(posedge clk_i)
        disable iff (reset_i)
        $rose(st.big));
    c_rom_big: cover property (@(posedge clk_i)
        disable iff (reset_i)
        rom_valid_o && big_mode_o);
endmodule : ebl_steer

// File: tb/ebl_host_model.sv
// ebl_host_model: scsi side sink for bytes the block sends out
`timescale 1ns/10ps
module ebl_host_model (
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic slow_i,
    input wire logic [7:0] byte_i,
    input wire logic byte_valid_i,
    output logic byte_ready_o
);
    logic [7:0] got[$];

    // slow mode stalls every other cycle so each byte must be held
    always @(posedge clk_i) begin
        if (reset_i) begin
            byte_ready_o <= 1'b0;
        end else begin
            byte_ready_o <= slow_i ? ~byte_ready_o : 1'b1;
            if (byte_valid_i && byte_ready_o) begin
                got.push_back(byte_i);
            end
        end
    end
endmodule : ebl_host_model

// File: tb/ebl_steer_tb.sv
// ebl_steer_tb: self-checking bench for the endian byte-lane steering
`timescale 1ns/10ps
module ebl_steer_tb;
    import ebl_pkg::*;
    logic clk_i = 1'b0;
    logic reset_i = 1'b1;
    logic ce_i = 1'b1;
    logic big_pin_i = 1'b0;
    logic [7:0] reg_addr_i = 8'h00;
    logic [31:0] reg_wdata_i = 32'h0;
    logic reg_byte_i = 1'b0;
    logic reg_wr_i = 1'b0;
    logic reg_rd_i = 1'b0;
    logic [7:0] scr_addr_i = 8'h00;
    logic scr_rd_i = 1'b0;
    logic rx_byte_valid_i = 1'b0;
    logic [7:0] rx_byte_i = 8'h00;
    logic rx_first_i = 1'b0;
    logic rx_last_i = 1'b0;
    logic [31:0] tx_word_i = 32'h0;
    logic tx_word_valid_i = 1'b0;
    logic rom_valid_i = 1'b0;
    logic [1:0] rom_addr_i = 2'h0;
    logic [7:0] rom_byte_i = 8'h00;
    logic slow = 1'b0;
    logic [31:0] reg_rdata_o, rx_word_o, rom_word_o;
    logic [7:0] scr_rdata_o, tx_byte_o;
    logic [3:0] rx_be_o, rom_be_o;
    logic rx_word_valid_o, tx_word_ready_o, tx_byte_valid_o;
    logic tx_byte_ready_i, rom_valid_o, big_mode_o;
    int error_cnt = 0;
    int n_tests = 0;

    // device under test and the host sink on its byte side
    ebl_steer #(.HAS_MODE_PIN(1'b1)) DUT (
        .clk_i(clk_i), .reset_i(reset_i), .ce_i(ce_i),
        .big_pin_i(big_pin_i), .reg_addr_i(reg_addr_i),
        .reg_wdata_i(reg_wdata_i), .reg_byte_i(reg_byte_i),
        .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
        .reg_rdata_o(reg_rdata_o), .scr_addr_i(scr_addr_i),
        .scr_rd_i(scr_rd_i), .scr_rdata_o(scr_rdata_o),
        .rx_byte_valid_i(rx_byte_valid_i), .rx_byte_i(rx_byte_i),
        .rx_first_i(rx_first_i), .rx_last_i(rx_last_i),
        .rx_word_o(rx_word_o), .rx_be_o(rx_be_o),
        .rx_word_valid_o(rx_word_valid_o), .tx_word_i(tx_word_i),
        .tx_word_valid_i(tx_word_valid_i),
        .tx_word_ready_o(tx_word_ready_o), .tx_byte_o(tx_byte_o),
        .tx_byte_valid_o(tx_byte_valid_o),
        .tx_byte_ready_i(tx_byte_ready_i), .rom_valid_i(rom_valid_i),
        .rom_addr_i(rom_addr_i), .rom_byte_i(rom_byte_i),
        .rom_word_o(rom_word_o), .rom_be_o(rom_be_o),
        .rom_valid_o(rom_valid_o), .big_mode_o(big_mode_o)
    );
    ebl_host_model HOST (
        .clk_i(clk_i), .reset_i(reset_i), .slow_i(slow),
        .byte_i(tx_byte_o), .byte_valid_i(tx_byte_valid_o),
        .byte_ready_o(tx_byte_ready_i)
    );

    // 50 ns bus clock
    always #25 clk_i = ~clk_i;

    task automatic end_of_test();
        if (error_cnt == 0 && n_tests > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : end_of_test

    // case equality so an unknown never counts as a match
    task automatic chk(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            error_cnt++;
            $display("MISMATCH %s exp %h seen %h", what, exp, seen);
        end
    endtask : chk

    function automatic logic [31:0] msk(input logic [3:0] be);
        msk = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
    endfunction : msk

    task automatic wr(input logic [7:0] a, input logic [31:0] d,
                      input logic b);
        @(posedge clk_i);
        reg_addr_i <= a;
        reg_wdata_i <= d;
        reg_byte_i <= b;
        reg_wr_i <= 1'b1;
        @(posedge clk_i);
        reg_wr_i <= 1'b0;
    endtask : wr

    // read data stands only in the cycle after the strobe
    task automatic rdc(input string what, input logic [7:0] a,
                       input logic b, input logic [31:0] e);
        @(posedge clk_i);
        reg_addr_i <= a;
        reg_byte_i <= b;
        reg_rd_i <= 1'b1;
        @(posedge clk_i);
        reg_rd_i <= 1'b0;
        #1 chk(what, reg_rdata_o, e);
    endtask : rdc

    task automatic scr(input logic [7:0] a, input logic [7:0] e);
        @(posedge clk_i);
        scr_addr_i <= a;
        scr_rd_i <= 1'b1;
        @(posedge clk_i);
        scr_rd_i <= 1'b0;
        #1 chk("script read", {24'h0, scr_rdata_o}, {24'h0, e});
    endtask : scr

    // stream n bytes back to back, lowest byte of bs first
    task automatic rxs(input logic [31:0] bs, input int n, input logic v,
                       input logic [31:0] ew, input logic [3:0] eb);
        for (int i = 0; i < n; i++) begin
            @(posedge clk_i);
            rx_byte_valid_i <= 1'b1;
            rx_byte_i <= bs[8*i +: 8];
            rx_first_i <= (i == 0);
            rx_last_i <= (i == n - 1);
        end
        @(posedge clk_i);
        rx_byte_valid_i <= 1'b0;
        #1 chk("rx valid", rx_word_valid_o, v);
        if (v) begin
            chk("rx be", rx_be_o, eb);
            chk("rx word", rx_word_o & msk(eb), ew & msk(eb));
        end
    endtask : rxs

    task automatic rom(input logic [1:0] a, input logic [31:0] ew,
                       input logic [3:0] eb);
        @(posedge clk_i);
        rom_valid_i <= 1'b1;
        rom_addr_i <= a;
        rom_byte_i <= 8'ha5;
        @(posedge clk_i);
        rom_valid_i <= 1'b0;
        #1 chk("rom valid", rom_valid_o, 1'b1);
        chk("rom be", rom_be_o, eb);
        chk("rom word", rom_word_o & msk(eb), ew);
    endtask : rom

    // word is held until the edge that sees ready high
    task automatic tx(input logic [31:0] w, input logic big);
        int k;
        k = 0;
        @(posedge clk_i);
        tx_word_i <= w;
        tx_word_valid_i <= 1'b1;
        do begin
            @(posedge clk_i);
            k++;
        end while (tx_word_ready_o !== 1'b1 && k < 50);
        tx_word_valid_i <= 1'b0;
        k = 0;
        while (HOST.got.size() < 4 && k < 100) begin
            @(posedge clk_i);
            k++;
        end
        chk("tx count", HOST.got.size(), 4);
        for (int n = 0; n < 4; n++) begin
            chk("tx byte", HOST.got.pop_front(), w[8*(big ? 3-n : n) +: 8]);
        end
    endtask : tx

    // one pass over every path in the given mode
    task automatic mode_run(input logic big);
        int l;
        logic [7:0] v;
        v = big ? 8'hc3 : 8'h5a;
        @(posedge clk_i);
        big_pin_i <= big;
        repeat (6) @(posedge clk_i);
        #1 chk("mode", big_mode_o, big);
        rdc("status", STATUS_OFS, 1'b0, {28'h0, big, 2'b00, big});
        wr(big ? 8'h03 : 8'h00, {24'h0, v}, 1'b1);
        wr(big ? 8'h02 : 8'h01, 32'hffffffff, 1'b1);
        rdc("ctl0 byte", big ? 8'h03 : 8'h00, 1'b1, {24'h0, v});
        rdc("ctl0 far byte", big ? 8'h00 : 8'h03, 1'b1, 32'h0);
        rdc("ctl0 dword", 8'h02, 1'b0, {24'h0, v});
        scr(8'h00, v);
        rxs(32'h44332211, 4, 1'b1, big ? 32'h11223344 : 32'h44332211,
            4'hf);
        rxs(32'h00006655, 2, 1'b1, big ? 32'h55660000 : 32'h00006655,
            big ? 4'hc : 4'h3);
        for (int a = 0; a < 4; a++) begin
            l = big ? 3 - a : a;
            rom(a[1:0], 32'ha5 << (8 * l), 4'h1 << l);
        end
        slow <= 1'b0;
        tx(32'h44332211, big);
        slow <= 1'b1;
        tx(32'hddccbbaa, big);
    endtask : mode_run

    // main sequence: reset values, both modes, then a disabled stream
    initial begin
        repeat (6) @(posedge clk_i);
        reset_i <= 1'b0;
        repeat (4) @(posedge clk_i);
        #1 chk("tx ready", tx_word_ready_o, 1'b1);
        rdc("ctl0 reset", SCTL0_OFS, 1'b0, {24'h0, SCTL0_RST});
        rdc("ctrl reset", CTRL_OFS, 1'b0, {31'h0, CTRL_EN_RST});
        wr(8'h0c, 32'hffffffff, 1'b0);
        rdc("unmapped", 8'h0c, 1'b0, 32'h0);
        mode_run(1'b0);
        mode_run(1'b1);
        mode_run(1'b0);
        // a write while the clock enable is low must be lost
        @(posedge clk_i);
        ce_i <= 1'b0;
        wr(CTRL_OFS, 32'h0, 1'b0);
        ce_i <= 1'b1;
        rdc("ctrl frozen", CTRL_OFS, 1'b0, {31'h0, CTRL_EN_RST});
        wr(CTRL_OFS, 32'h0, 1'b0);
        rdc("ctrl off", CTRL_OFS, 1'b0, 32'h0);
        chk("tx ready off", tx_word_ready_o, 1'b0);
        rxs(32'h44332211, 4, 1'b0, 32'h0, 4'h0);
        end_of_test();
    end

    // watchdog well beyond the few hundred cycles the run needs
    initial begin
        repeat (5000) @(posedge clk_i);
        error_cnt++;
        end_of_test();
    end
endmodule : ebl_steer_tb
